// File: hw/dimc_sync.sv
`default_nettype none
module dimc_sync #(
   parameter int WIDTH = 1
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= asyncIn;
         sync_reg <= meta_reg;
      end
   end
   assign syncOut = sync_reg;
endmodule
`default_nettype wire

// File: hw/direct_input_mode_control.sv
// Our own choices: the register addresses and the Wishbone slave port.
`default_nettype none
module direct_input_mode_control
   import dimc_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [NUM_IN-1:0] parallelInput,
   input wire logic sleepRequestN,
   input wire logic [NUM_PWM-1:0] pwmGen,
   input wire logic serialSelectN,
   input wire logic serialDataOutInt,
   output logic serialDataOut,
   output logic serialDataOutEn,
   output logic serialEnable,
   output logic [NUM_CH-1:0] channelDrive,
   output logic undervoltageEnable,
   output logic limpHome,
   output logic sleepMode,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [3:0] wbSel,
   input wire logic [7:0] wbAdr,
   input wire logic [31:0] wbDatW,
   output logic [31:0] wbDatR,
   output logic wbAck
);
   // ==========================================================
   // Input synchronisation
   // ==========================================================
   logic [NUM_IN:0] pinsSync;
   logic [NUM_IN-1:0] inSync;
   logic idleHigh;

   dimc_sync #(.WIDTH(NUM_IN + 1)) uSync (
      .core_clk(core_clk),
      .resetn(resetn),
      .asyncIn({sleepRequestN, parallelInput}),
      .syncOut(pinsSync)
   );
   assign inSync = pinsSync[NUM_IN-1:0];
   assign idleHigh = pinsSync[NUM_IN];

   // ==========================================================
   // Mode decision
   // ==========================================================
   // The controller must hold each sleep-request level for the minimum
   // transition time; the mode follows the synchronised level directly.
   dimc_mode_t mode_reg, mode_next;
   always_comb begin
      mode_next = MODE_ACTIVE;
      if (!idleHigh && |inSync) begin
         mode_next = MODE_LIMP;
      end else if (!idleHigh) begin
         mode_next = MODE_SLEEP;
      end
   end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         mode_reg <= MODE_SLEEP;
      end else begin
         mode_reg <= mode_next;
      end
   end

   logic inLimp, inSleep;
   always_comb begin
      inLimp = 1'b0;
      inSleep = 1'b0;
      case (mode_reg)
         MODE_LIMP: inLimp = 1'b1;
         MODE_SLEEP: inSleep = 1'b1;
         MODE_ACTIVE: ;
         default: inSleep = 1'b1;
      endcase
   end
   assign limpHome = inLimp;
   assign sleepMode = inSleep;
   assign undervoltageEnable = !inSleep;
   // Serial interface is gated off in sleep so no transfer is accepted.
   assign serialEnable = !inSleep;
   assign serialDataOutEn = !inSleep && !serialSelectN;
   assign serialDataOut = serialDataOutInt && serialDataOutEn;

   // ==========================================================
   // Software registers
   // ==========================================================
   dimc_regs_t regs_reg, regs_next;
   logic ack_reg, ack_next;
   logic [31:0] rdat_reg, rdat_next;
   logic busReq;
   assign busReq = wbCyc && wbStb && !ack_reg;

   function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
      merge8 = s[0] ? d[7:0] : old;
   endfunction

   always_comb begin
      regs_next = regs_reg;
      ack_next = busReq;
      rdat_next = rdat_reg;
      if (busReq && wbWe) begin
         case (wbAdr)
            OFS_OUT: regs_next.outBits = merge8(regs_reg.outBits, wbDatW, wbSel);
            OFS_MAP0: regs_next.map0 = merge8(regs_reg.map0, wbDatW, wbSel);
            OFS_MAP1: regs_next.map1 = merge8(regs_reg.map1, wbDatW, wbSel);
            OFS_PWMMAP0: regs_next.pwmMap0 = merge8(regs_reg.pwmMap0, wbDatW, wbSel);
            OFS_PWMMAP1: regs_next.pwmMap1 = merge8(regs_reg.pwmMap1, wbDatW, wbSel);
            default: ;
         endcase
      end
      if (busReq && !wbWe) begin
         case (wbAdr)
            OFS_OUT: rdat_next = {24'h000000, regs_reg.outBits};
            OFS_MAP0: rdat_next = {24'h000000, regs_reg.map0};
            OFS_MAP1: rdat_next = {24'h000000, regs_reg.map1};
            OFS_PWMMAP0: rdat_next = {24'h000000, regs_reg.pwmMap0};
            OFS_PWMMAP1: rdat_next = {24'h000000, regs_reg.pwmMap1};
            OFS_MONITOR: rdat_next = {30'h0, inSync};
            OFS_STATUS: rdat_next = {28'h0000000, !inSleep, !inSleep, inSleep, inLimp};
            default: rdat_next = 32'h00000000;
         endcase
      end
      // A low sleep-request level holds the registers at default.
      if (!idleHigh) begin
         regs_next = '{outBits: RST_OUT, map0: RST_MAP0, map1: RST_MAP1,
                       pwmMap0: RST_PWMMAP, pwmMap1: RST_PWMMAP};
      end
   end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         regs_reg <= '{outBits: RST_OUT, map0: RST_MAP0, map1: RST_MAP1,
                       pwmMap0: RST_PWMMAP, pwmMap1: RST_PWMMAP};
         ack_reg <= 1'b0;
         rdat_reg <= 32'h00000000;
      end else begin
         regs_reg <= regs_next;
         ack_reg <= ack_next;
         rdat_reg <= rdat_next;
      end
   end
   assign wbAck = ack_reg;
   assign wbDatR = rdat_reg;

   // ==========================================================
   // Channel drive
   // ==========================================================
   logic [NUM_CH-1:0] drive_reg, drive_next;
   always_comb begin
      drive_next = regs_reg.outBits
                 | ({NUM_CH{pwmGen[0]}} & regs_reg.pwmMap0)
                 | ({NUM_CH{pwmGen[1]}} & regs_reg.pwmMap1)
                 | ({NUM_CH{inSync[0]}} & regs_reg.map0)
                 | ({NUM_CH{inSync[1]}} & regs_reg.map1);
      if (inLimp) begin
         // Registers sit at default in limp-home, so only default channels follow inputs.
         drive_next = ({NUM_CH{inSync[0]}} & RST_MAP0) | ({NUM_CH{inSync[1]}} & RST_MAP1);
      end else if (inSleep) begin
         drive_next = '0;
      end
   end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         drive_reg <= '0;
      end else begin
         drive_reg <= drive_next;
      end
   end
   assign channelDrive = drive_reg;
endmodule
`default_nettype wire

// File: include/dimc_pkg.sv
// Summary of operation
// - After reset input 0 drives channel 2 and input 1 drives channel 3.
// - Software may program each input's channel map to add or replace channels.
// - Each channel is the OR of output bit, mapped PWM and mapped inputs.
// - Input level monitor shows input levels, also during limp-home mode.
// - Any input high with sleep-request low enters limp-home, default channels follow the inputs.
// - Sleep-request low with all inputs low enters sleep mode.
// - Sleep-request low resets every software register to its default.
// - Sleep-request low with inputs low disables both undervoltage detectors.
// - In sleep the serial interface refuses transfers and keeps data output released.
`default_nettype none
package dimc_pkg;
   localparam int NUM_CH = 8;
   localparam int NUM_IN = 2;
   localparam int NUM_PWM = 2;
   localparam logic [7:0] OFS_OUT = 8'h00;
   localparam logic [7:0] OFS_MAP0 = 8'h04;
   localparam logic [7:0] OFS_MAP1 = 8'h08;
   localparam logic [7:0] OFS_PWMMAP0 = 8'h0c;
   localparam logic [7:0] OFS_PWMMAP1 = 8'h10;
   localparam logic [7:0] OFS_MONITOR = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] RST_OUT = 8'h00;
   localparam logic [7:0] RST_MAP0 = 8'h04;
   localparam logic [7:0] RST_MAP1 = 8'h08;
   localparam logic [7:0] RST_PWMMAP = 8'h00;
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_UV_EN = 2;
   localparam int STAT_SERIAL_EN = 3;
   typedef enum {MODE_ACTIVE, MODE_LIMP, MODE_SLEEP} dimc_mode_t;
   typedef struct packed {
      logic [7:0] outBits;
      logic [7:0] map0;
      logic [7:0] map1;
      logic [7:0] pwmMap0;
      logic [7:0] pwmMap1;
   } dimc_regs_t;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } dimc_wb_req_t;
endpackage
`default_nettype wire

// File: tb/dimc_mcu_model.sv
`default_nettype none
module dimc_mcu_model #(
   parameter int HOLD_CYC = 6
) (
   input wire logic core_clk,
   input wire logic wantSleepN,
   input wire logic [1:0] wantIn,
   output logic sleepRequestN,
   output logic [1:0] parallelInput
);
   timeunit 1ns;
   timeprecision 1ns;
   int held = 0;
   initial sleepRequestN = 1'h0;
   initial parallelInput = 2'h0;
   // A new sleep-request level waits until the old one has stood its minimum time, so every mode change completes; input levels follow wantIn each cycle.
   always @(posedge core_clk) begin
      parallelInput <= wantIn;
      held <= (held < HOLD_CYC) ? held + 1 : held;
      if (wantSleepN != sleepRequestN && held >= HOLD_CYC) begin
         sleepRequestN <= wantSleepN;
         held <= 0;
      end
   end
endmodule
`default_nettype wire

// File: tb/dimc_monitor.sv
`default_nettype none
module dimc_monitor
   import dimc_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [NUM_IN-1:0] parallelInput,
   input wire logic sleepRequestN,
   input wire logic serialSelectN,
   input wire logic serialDataOutEn,
   input wire logic serialEnable,
   input wire logic [NUM_CH-1:0] channelDrive,
   input wire logic undervoltageEnable,
   input wire logic limpHome,
   input wire logic sleepMode,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbAck
);
   // ==========
   // Mode, pin and bus checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   sequence sleepPins; (!sleepRequestN && parallelInput == 2'h0)[*4]; endsequence
   sequence limpPins; (!sleepRequestN && parallelInput == 2'h3)[*5]; endsequence
   mode_active_a: assert property (sleepRequestN[*4] |-> !sleepMode && !limpHome
      && undervoltageEnable && serialEnable) else $error("not active");
   mode_sleep_a: assert property (sleepPins |-> sleepMode && !limpHome) else $error("not sleeping");
   limp_drive_a: assert property (limpPins |-> limpHome && channelDrive == 8'h0c) else $error("limp drive");
   uv_off_a: assert property (sleepPins |-> !undervoltageEnable) else $error("uv detector enable");
   serial_gate_a: assert property (sleepPins |-> !serialEnable) else $error("serial enable");
   so_release_a: assert property (sleepPins |-> !serialDataOutEn) else $error("so enable");
   bus_answer_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck) else $error("no ack");
   ack_pulse_a: assert property (wbAck |=> !wbAck) else $error("ack too long");
endmodule
bind direct_input_mode_control dimc_monitor dimc_monitor_i (.core_clk, .resetn, .parallelInput, .sleepRequestN,
   .serialSelectN, .serialDataOutEn, .serialEnable, .channelDrive, .undervoltageEnable, .limpHome, .sleepMode,
   .wbCyc, .wbStb, .wbAck);
`default_nettype wire

// File: tb/tb_direct_input_mode_control.sv
`default_nettype none
module tb_direct_input_mode_control
   import dimc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin nMismatch++; $display("mismatch %s exp %h got %h", nm, e, g); end end
   logic core_clk = 1'h0;
   logic resetn = 1'h0;
   logic wantSleepN = 1'h0;
   logic [1:0] wantIn = 2'h0;
   logic [NUM_PWM-1:0] pwmGen = 2'h0;
   logic serialSelectN = 1'h1;
   logic serialDataOutInt = 1'h0;
   logic wbCyc = 1'h0, wbStb = 1'h0, wbWe = 1'h0;
   logic [3:0] wbSel = 4'h0;
   logic [7:0] wbAdr = 8'h00;
   logic [31:0] wbDatW = 32'h0;
   logic [NUM_IN-1:0] parallelInput;
   logic sleepRequestN, serialDataOut, serialDataOutEn, undervoltageEnable, limpHome, sleepMode, wbAck;
   logic serialEnable;
   logic [NUM_CH-1:0] channelDrive;
   logic [31:0] wbDatR;
   int nMismatch = 0;
   int checked = 0;
   logic [7:0] rd;
   always #20 core_clk = ~core_clk;
   dimc_mcu_model dimc_mcu_model_i (.core_clk, .wantSleepN, .wantIn, .sleepRequestN, .parallelInput);
   direct_input_mode_control direct_input_mode_control_i (.core_clk, .resetn, .parallelInput, .sleepRequestN,
      .pwmGen, .serialSelectN, .serialDataOutInt, .serialDataOut, .serialDataOutEn, .serialEnable,
      .channelDrive, .undervoltageEnable, .limpHome, .sleepMode, .wbCyc, .wbStb, .wbWe, .wbSel, .wbAdr, .wbDatW,
      .wbDatR, .wbAck);
   // ==========
   // Bus and pin tasks
   task automatic stop_test;
      if (nMismatch == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d);
      int n;
      wbCyc <= 1'h1;
      wbStb <= 1'h1;
      wbWe <= we;
      wbSel <= 4'h1;
      wbAdr <= a;
      wbDatW <= {24'h0, d};
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (wbAck !== 1'h1 && n < 20);
      if (n >= 20) begin
         nMismatch++;
         stop_test();
      end
      rd = wbDatR[7:0];
      wbCyc <= 1'h0;
      wbStb <= 1'h0;
      @(posedge core_clk);
   endtask
   task automatic chkRd(input string nm, input logic [7:0] a, input logic [7:0] e);
      xfer(1'h0, a, 8'h00);
      `CHK(nm, e, rd)
   endtask
   task automatic pins(input logic sn, input logic [1:0] i);
      wantSleepN <= sn;
      wantIn <= i;
      repeat (12) @(posedge core_clk);
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      resetn <= 1'h1;
      pins(1'h1, 2'h0);
      chkRd("map0", OFS_MAP0, RST_MAP0);
      chkRd("map1", OFS_MAP1, RST_MAP1);
      pins(1'h1, 2'h3);
      `CHK("drive", RST_MAP0 | RST_MAP1, channelDrive)
      chkRd("monitor", OFS_MONITOR, 8'h03);
      xfer(1'h1, OFS_MAP0, 8'h81);
      xfer(1'h1, OFS_OUT, 8'h20);
      xfer(1'h1, OFS_PWMMAP1, 8'h40);
      pwmGen <= 2'h2;
      serialSelectN <= 1'h0;
      serialDataOutInt <= 1'h1;
      pins(1'h1, 2'h1);
      `CHK("drive", 8'h81 | 8'h20 | 8'h40, channelDrive)
      `CHK("soEn", 1'h1, serialDataOutEn)
      `CHK("so", 1'h1, serialDataOut)
      `CHK("serEn", 1'h1, serialEnable)
      pins(1'h0, 2'h1);
      `CHK("limp", 1'h1, limpHome)
      `CHK("drive", RST_MAP0, channelDrive)
      chkRd("monitor", OFS_MONITOR, 8'h01);
      xfer(1'h1, OFS_MAP0, 8'h81);
      chkRd("map0", OFS_MAP0, RST_MAP0);
      chkRd("status", OFS_STATUS, 8'h0d);
      pins(1'h0, 2'h3);
      `CHK("drive", RST_MAP0 | RST_MAP1, channelDrive)
      pins(1'h0, 2'h0);
      `CHK("sleep", 1'h1, sleepMode)
      `CHK("uv", 1'h0, undervoltageEnable)
      `CHK("soEn", 1'h0, serialDataOutEn)
      `CHK("serEn", 1'h0, serialEnable)
      pins(1'h1, 2'h0);
      chkRd("out", OFS_OUT, RST_OUT);
      chkRd("unmapped", 8'h3c, 8'h00);
      stop_test();
   end
endmodule
`default_nettype wire
